// ==== verilog/irq_pkg.sv ====
// package: constants and carrier types for the interrupt and trap controller
package irq_pkg;
   localparam int NODES = 112;
   localparam int NCH = 8;
   localparam int NSH = 4;
   localparam int NTRAP = 8;
   localparam int NRT = 4;
   localparam int NODE_W = 10;
   // register word indices; byte address is four times the index
   localparam logic [9:0] W_SEL = 10'h080;
   localparam logic [9:0] W_TFLG = 10'h081;
   localparam logic [9:0] W_SWT = 10'h082;
   localparam logic [9:0] W_CFG = 10'h083;
   localparam logic [9:0] W_STKH = 10'h084;
   localparam logic [9:0] W_STKL = 10'h085;
   localparam logic [9:0] W_GLO = 10'h086;
   localparam logic [9:0] W_GHI = 10'h087;
   localparam logic [9:0] W_GPERM = 10'h088;
   localparam logic [9:0] W_EDGE = 10'h089;
   localparam logic [9:0] W_ROUTE = 10'h08a;
   localparam logic [9:0] W_GATE = 10'h08b;
   localparam logic [9:0] W_STAT = 10'h08c;
   localparam logic [4:0] W_CH = 5'h06;
   // config bits
   localparam int CFG_JC = 0;
   localparam int CFG_GEN = 1;
   localparam int CFG_SYS0 = 2;
   localparam int CFG_SYS1 = 3;
   // channel control bits
   localparam int CTL_INCS = 0;
   localparam int CTL_INCD = 1;
   localparam int CTL_WORD = 2;
   localparam int CTL_CONT = 3;
   localparam int PAT_POS = 8;
   // trap flag positions, lower index is higher priority
   localparam int T_SYS0 = 0;
   localparam int T_SYS1 = 1;
   localparam int T_OVF = 2;
   localparam int T_UNF = 3;
   localparam int T_PROT = 4;
   // reset values, software trap code, node vector base and trap level
   localparam logic [3:0] CFG_RST = 4'h1;
   localparam logic [15:0] STKH_RST = 16'hffff;
   localparam logic [15:0] STKL_RST = 16'h0000;
   localparam logic [7:0] SWT_TRAP = 8'h80;
   localparam logic [7:0] VEC_NODE = 8'h10;
   localparam logic [3:0] LVL_TRAP = 4'hf;
   // response time in cpu clocks, with and without jump cache
   localparam int LAT_JC = 7;
   localparam int LAT_NJC = 11;
   localparam logic [3:0] LAT_JC_CNT = 4'(LAT_JC - 2);
   localparam logic [3:0] LAT_NJC_CNT = 4'(LAT_NJC - 2);
   typedef struct packed {
      logic flag;
      logic en;
      logic [3:0] prio;
      logic xfer;
      logic [2:0] ch;
   } node_t;
   typedef struct packed {
      logic [3:0] ctl;
      logic [7:0] cnt;
      logic [15:0] dst;
      logic [15:0] src;
   } chan_t;
   typedef struct packed {
      logic req;
      logic trap;
      logic [7:0] vec;
      logic [3:0] lvl;
   } svc_t;
   typedef struct packed {
      logic req;
      logic word;
      logic [15:0] src;
      logic [15:0] dst;
   } xfer_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_REQ = 2'b10} state_t;
endpackage

// ==== verilog/irq_trap_ctrl.sv ====
// interrupt nodes, transfer channels, request router and trap logic
// Summary of operation
// R1 - node routes to vectored or transfer service
// R2 - vectored grant redirects cpu to vector
// R3 - transfer service takes one cycle only
// R4 - transfer moves byte/word, bumps chosen pointers
// R5 - counter decrements per transfer, not continuous
// R6 - counter at zero gives vectored interrupt
// R7 - eight independent transfer channels
// R8 - response after 7 or 11 clocks
// R9 - 112 nodes with flag, enable, priority
// R10 - select registers pick shared node sources
// R11 - router: 4 inputs, matrix, 4 gates
// R12 - edge stage: rising, falling or both
// R13 - gate forwards on pattern match or miss
// R14 - trap branches to its own vector
// R15 - each trap sets its own flag
// R16 - trap preempts unless same or higher trap active
// R17 - interrupts wait while trap in service
// R18 - three service pins make two traps
// R19 - software trap number enters service
// R20 - writing flag bit raises request
// R21 - stack accesses checked against both limits
// R22 - guard violation raises protection trap
// R23 - highest priority wins, must beat cpu
`timescale 1ns/100ps
module irq_trap_ctrl
   import irq_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NODES-NSH-1:0] node_src,
   input wire logic [7:0] shared_src,
   input wire logic [3:0] ext_req,
   input wire logic [2:0] ext_service_pin,
   input wire logic [2:0] hw_trap,
   input wire logic stk_acc,
   input wire logic [15:0] sp,
   input wire logic guard_acc,
   input wire logic guard_wr,
   input wire logic [23:0] guard_addr,
   input wire logic [3:0] cpu_lvl,
   input wire logic cpu_ack,
   input wire logic trap_done,
   output svc_t svc,
   output xfer_t xfer
);
   node_t node_r [NODES];
   chan_t chan_r [NCH];
   logic wr_r;
   logic [9:0] wa_r;
   logic [9:0] ra;
   logic addr_ph;
   logic [31:0] rd_nxt;
   logic [11:0] sel_r;
   logic [3:0] cfg_r;
   logic [15:0] stkh_r;
   logic [15:0] stkl_r;
   logic [23:0] glo_r;
   logic [23:0] ghi_r;
   logic [1:0] gperm_r;
   logic [7:0] edge_r;
   logic [15:0] route_r;
   logic [11:0] gate_r;
   logic [3:0] ext_prev_r;
   logic [2:0] pin_prev_r;
   logic [3:0] ext_evt;
   logic [3:0] rt_nxt;
   logic [3:0] rt_evt_r;
   logic [NTRAP-1:0] tflag_r;
   logic [NTRAP-1:0] pend_r;
   logic [NTRAP-1:0] tset;
   logic [NTRAP-1:0] tclr;
   logic swt;
   logic viol;
   logic t_ok;
   logic [2:0] t_j;
   logic n_ok;
   logic [6:0] n_i;
   logic [3:0] n_p;
   state_t st_r;
   logic cur_trap_r;
   logic [6:0] cur_idx_r;
   logic [3:0] cnt_r;
   logic [3:0] lat;
   logic trap_act_r;
   logic [2:0] trap_idx_r;
   node_t cn;
   chan_t cc;
   logic go_x;
   logic xfer_go;
   logic last;
   logic node_clr;

   // bus slave: zero wait state, writes land at the end of the data phase
   assign addr_ph = hsel && htrans[1] && hready;
   assign ra = haddr[11:2];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_r <= 1'b0;
         wa_r <= '0;
         hrdata <= '0;
      end else begin
         wr_r <= addr_ph && hwrite;
         if (addr_ph) begin
            wa_r <= ra;
         end
         if (addr_ph && !hwrite) begin
            hrdata <= rd_nxt;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // a read in the data phase of a write still sees the old value
   always_comb begin
      rd_nxt = '0;
      if (ra < 10'(NODES)) begin
         rd_nxt[NODE_W-1:0] = node_r[ra[6:0]];
      end else if (ra[9:5] == W_CH) begin
         case (ra[1:0])
            2'h0: rd_nxt[15:0] = chan_r[ra[4:2]].src;
            2'h1: rd_nxt[15:0] = chan_r[ra[4:2]].dst;
            2'h2: rd_nxt[7:0] = chan_r[ra[4:2]].cnt;
            default: rd_nxt[3:0] = chan_r[ra[4:2]].ctl;
         endcase
      end else begin
         case (ra)
            W_SEL: rd_nxt[11:0] = sel_r;
            W_TFLG: rd_nxt[7:0] = tflag_r;
            W_CFG: rd_nxt[3:0] = cfg_r;
            W_STKH: rd_nxt[15:0] = stkh_r;
            W_STKL: rd_nxt[15:0] = stkl_r;
            W_GLO: rd_nxt[23:0] = glo_r;
            W_GHI: rd_nxt[23:0] = ghi_r;
            W_GPERM: rd_nxt[1:0] = gperm_r;
            W_EDGE: rd_nxt[7:0] = edge_r;
            W_ROUTE: rd_nxt[15:0] = route_r;
            W_GATE: rd_nxt[11:0] = gate_r;
            W_STAT: rd_nxt[13:0] = {trap_act_r, trap_idx_r, cur_trap_r, cur_idx_r, st_r};
            default: rd_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sel_r <= '0;
         cfg_r <= CFG_RST;
         stkh_r <= STKH_RST;
         stkl_r <= STKL_RST;
         glo_r <= '0;
         ghi_r <= '0;
         gperm_r <= '0;
         edge_r <= '0;
         route_r <= '0;
         gate_r <= '0;
      end else if (wr_r) begin
         case (wa_r)
            W_SEL: sel_r <= hwdata[11:0];
            W_CFG: cfg_r <= hwdata[3:0];
            W_STKH: stkh_r <= hwdata[15:0];
            W_STKL: stkl_r <= hwdata[15:0];
            W_GLO: glo_r <= hwdata[23:0];
            W_GHI: ghi_r <= hwdata[23:0];
            W_GPERM: gperm_r <= hwdata[1:0];
            W_EDGE: edge_r <= hwdata[7:0];
            W_ROUTE: route_r <= hwdata[15:0];
            W_GATE: gate_r <= hwdata[11:0];
            default: ;
         endcase
      end
   end

   // external request router
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_prev_r <= '0;
         pin_prev_r <= '0;
         rt_evt_r <= '0;
      end else begin
         ext_prev_r <= ext_req;
         pin_prev_r <= ext_service_pin;
         rt_evt_r <= rt_nxt;
      end
   end

   for (genvar i = 0; i < NRT; i++) begin : g_rt
      logic any;
      logic match;
      assign ext_evt[i] = (ext_req[i] && !ext_prev_r[i] && edge_r[2*i]) ||
                          (!ext_req[i] && ext_prev_r[i] && edge_r[2*i+1]); // see R12
      assign any = |(ext_evt & route_r[4*i +: 4]); // see R11
      assign match = ext_req == gate_r[PAT_POS +: 4];
      always_comb begin
         case (gate_r[2*i +: 2]) // see R13
            2'h0: rt_nxt[i] = 1'b0;
            2'h1: rt_nxt[i] = any;
            2'h2: rt_nxt[i] = any && match;
            default: rt_nxt[i] = any && !match;
         endcase
      end
   end

   // trap sources
   assign viol = cfg_r[CFG_GEN] && guard_acc && guard_addr >= glo_r && guard_addr <= ghi_r &&
                 (guard_wr ? !gperm_r[1] : !gperm_r[0]); // see R22
   assign swt = wr_r && wa_r == W_SWT;

   always_comb begin
      tset = '0;
      tset[T_SYS0] = cfg_r[CFG_SYS0] && ext_service_pin[0] && !pin_prev_r[0]; // see R18
      tset[T_SYS1] = cfg_r[CFG_SYS1] && |(ext_service_pin[2:1] & ~pin_prev_r[2:1]); // see R18
      tset[T_OVF] = stk_acc && sp > stkh_r; // see R21
      tset[T_UNF] = stk_acc && sp < stkl_r; // see R21
      tset[T_PROT] = viol;
      tset[NTRAP-1:T_PROT+1] = hw_trap;
      if (swt && hwdata[7:3] == SWT_TRAP[7:3]) begin
         tset[hwdata[2:0]] = 1'b1; // see R19
      end
   end

   assign tclr = (st_r == ST_REQ && cpu_ack && cur_trap_r) ? (8'h01 << cur_idx_r[2:0]) : '0;

   // set wins over both the software clear and the service clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tflag_r <= '0;
         pend_r <= '0;
      end else begin
         tflag_r <= (tflag_r & ~((wr_r && wa_r == W_TFLG) ? hwdata[7:0] : 8'h00)) | tset; // see R15
         pend_r <= (pend_r & ~tclr) | tset;
      end
   end

   always_comb begin
      t_ok = 1'b0;
      t_j = '0;
      for (int k = NTRAP - 1; k >= 0; k--) begin
         if (pend_r[k]) begin
            t_ok = 1'b1;
            t_j = 3'(k);
         end
      end
      if (trap_act_r && t_j >= trap_idx_r) begin
         t_ok = 1'b0; // see R16
      end
   end

   // node arbitration; ties go to the lower node number
   always_comb begin
      n_ok = 1'b0;
      n_i = '0;
      n_p = '0;
      for (int k = 0; k < NODES; k++) begin
         if (node_r[k].flag && node_r[k].en && (!n_ok || node_r[k].prio > n_p)) begin
            n_ok = 1'b1;
            n_i = 7'(k);
            n_p = node_r[k].prio;
         end
      end
      n_ok = n_ok && n_p > cpu_lvl; // see R23
   end

   assign cn = node_r[cur_idx_r];
   assign cc = chan_r[cn.ch];
   assign go_x = !cur_trap_r && cn.xfer && (cc.cnt != 8'h00 || cc.ctl[CTL_CONT]); // see R1
   assign xfer_go = st_r == ST_WAIT && cnt_r == 4'h0 && go_x;
   // the last transfer keeps the flag so the node comes back vectored
   assign last = !cc.ctl[CTL_CONT] && cc.cnt == 8'h01; // see R6
   assign node_clr = (st_r == ST_REQ && cpu_ack && !cur_trap_r) || (xfer_go && !last);
   assign lat = cfg_r[CFG_JC] ? LAT_JC_CNT : LAT_NJC_CNT;

   for (genvar i = 0; i < NODES; i++) begin : g_node
      logic hs;
      if (i >= NODES - NSH) begin : g_sh
         assign hs = shared_src[sel_r[(i-(NODES-NSH))*3 +: 3]]; // see R10
      end else if (i < NRT) begin : g_rtn
         assign hs = node_src[i] || rt_evt_r[i];
      end else begin : g_dir
         assign hs = node_src[i];
      end
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            node_r[i] <= '0;
         end else begin
            if (wr_r && wa_r == 10'(i)) begin
               node_r[i] <= hwdata[NODE_W-1:0]; // see R9
            end
            if (node_clr && cur_idx_r == 7'(i)) begin
               node_r[i].flag <= 1'b0;
            end
            if (hs || (swt && hwdata[7:0] == 8'(i))) begin
               node_r[i].flag <= 1'b1; // see R20
            end
         end
      end
   end

   for (genvar c = 0; c < NCH; c++) begin : g_ch // see R7
      logic [15:0] step;
      assign step = chan_r[c].ctl[CTL_WORD] ? 16'h0002 : 16'h0001;
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            chan_r[c] <= '0;
         end else begin
            if (wr_r && wa_r[9:5] == W_CH && wa_r[4:2] == 3'(c)) begin
               case (wa_r[1:0])
                  2'h0: chan_r[c].src <= hwdata[15:0];
                  2'h1: chan_r[c].dst <= hwdata[15:0];
                  2'h2: chan_r[c].cnt <= hwdata[7:0];
                  default: chan_r[c].ctl <= hwdata[3:0];
               endcase
            end
            if (xfer_go && cn.ch == 3'(c)) begin
               if (chan_r[c].ctl[CTL_INCS]) begin
                  chan_r[c].src <= chan_r[c].src + step; // see R4
               end
               if (chan_r[c].ctl[CTL_INCD]) begin
                  chan_r[c].dst <= chan_r[c].dst + step; // see R4
               end
               if (!chan_r[c].ctl[CTL_CONT]) begin
                  chan_r[c].cnt <= chan_r[c].cnt - 8'h01; // see R5
               end
            end
         end
      end
   end

   // service sequencer; a newer request waits until the current one is done
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= ST_IDLE;
         cur_trap_r <= 1'b0;
         cur_idx_r <= '0;
         cnt_r <= '0;
         svc <= '0;
         xfer <= '0;
      end else begin
         xfer.req <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (t_ok) begin
                  cur_trap_r <= 1'b1; // see R14
                  cur_idx_r <= {4'h0, t_j};
                  cnt_r <= lat; // see R8
                  st_r <= ST_WAIT;
               end else if (n_ok && !trap_act_r) begin // see R17
                  cur_trap_r <= 1'b0;
                  cur_idx_r <= n_i;
                  cnt_r <= lat; // see R8
                  st_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (cnt_r != 4'h0) begin
                  cnt_r <= cnt_r - 4'h1;
               end else if (go_x) begin
                  xfer.req <= 1'b1; // see R3
                  xfer.word <= cc.ctl[CTL_WORD];
                  xfer.src <= cc.src;
                  xfer.dst <= cc.dst;
                  st_r <= ST_IDLE;
               end else begin
                  svc.req <= 1'b1; // see R2
                  svc.trap <= cur_trap_r;
                  svc.vec <= cur_trap_r ? {5'h00, cur_idx_r[2:0]} : VEC_NODE + {1'b0, cur_idx_r};
                  svc.lvl <= cur_trap_r ? LVL_TRAP : cn.prio;
                  st_r <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (cpu_ack) begin
                  svc.req <= 1'b0;
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // trap in service; acceptance wins over a same-cycle done
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trap_act_r <= 1'b0;
         trap_idx_r <= '0;
      end else begin
         if (trap_done) begin
            trap_act_r <= 1'b0;
         end
         if (st_r == ST_REQ && cpu_ack && cur_trap_r) begin
            trap_act_r <= 1'b1; // see R16
            trap_idx_r <= cur_idx_r[2:0];
         end
      end
   end
endmodule // irq_trap_ctrl

// ==== tb/irq_trap_ctrl_chk.sv ====
// checker: port-level properties of the interrupt and trap controller
`timescale 1ns/100ps
module irq_trap_chk
   import irq_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic cpu_ack,
   input wire svc_t svc,
   input wire xfer_t xfer
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_bus_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_bus_ready: assert property ($past(nrst) && $past(nrst, 2) |-> hreadyout)
      else $error("slave inserted a wait state");
   a_svc_hold: assert property (svc.req && !cpu_ack |=> svc.req && $stable(svc))
      else $error("service request moved before acceptance");
   a_svc_drop: assert property (svc.req && cpu_ack |=> !svc.req)
      else $error("service request kept after acceptance");
   a_trap_level: assert property (svc.req && svc.trap |-> svc.lvl == LVL_TRAP && svc.vec < 8'(NTRAP))
      else $error("trap service with wrong level or vector");
   a_node_vector: assert property (svc.req && !svc.trap |-> svc.vec >= VEC_NODE && svc.vec < VEC_NODE + 8'(NODES))
      else $error("node service vector out of range");
   a_xfer_pulse: assert property (xfer.req |=> !xfer.req)
      else $error("transfer took more than one cycle");
   a_xfer_hold: assert property ($changed({xfer.word, xfer.src, xfer.dst}) |-> xfer.req)
      else $error("transfer fields changed without a transfer");
endmodule // irq_trap_chk

bind irq_trap_ctrl irq_trap_chk u_chk (
   .clk(clk),
   .nrst(nrst),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .cpu_ack(cpu_ack),
   .svc(svc),
   .xfer(xfer)
);

// ==== tb/cpu_partner.sv ====
// cpu model: accepts service requests and finishes trap services
`timescale 1ns/100ps
module cpu_partner
   import irq_pkg::*;
#(
   parameter int TRAP_LEN = 20
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire svc_t svc,
   input wire logic [3:0] ack_delay,
   output logic cpu_ack,
   output logic trap_done,
   output logic in_trap
);
   int wait_r;
   int busy_r;
   // one service at a time; nested traps are not modelled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cpu_ack <= 1'b0;
         trap_done <= 1'b0;
         in_trap <= 1'b0;
         wait_r <= 0;
         busy_r <= 0;
      end else begin
         cpu_ack <= 1'b0;
         trap_done <= 1'b0;
         if (svc.req && !cpu_ack) begin
            if (wait_r >= int'(ack_delay)) begin
               cpu_ack <= 1'b1;
               wait_r <= 0;
               busy_r <= TRAP_LEN;
               if (svc.trap) begin
                  in_trap <= 1'b1;
               end
            end else begin
               wait_r <= wait_r + 1;
            end
         end else if (in_trap && busy_r == 0) begin
            trap_done <= 1'b1;
            in_trap <= 1'b0;
         end else if (in_trap) begin
            busy_r <= busy_r - 1;
         end
      end
   end
endmodule // cpu_partner

// ==== tb/tb_irq_trap_ctrl.sv ====
// testbench: register bus, vectored, transfer and trap scenarios
`timescale 1ns/100ps
module tb_irq_trap_ctrl
   import irq_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [NODES-NSH-1:0] node_src = '0;
   logic [3:0] ext_req = 4'h0;
   logic [7:0] shared_src = 8'h0;
   logic [2:0] ext_service_pin = 3'h0;
   logic [2:0] hw_trap = 3'h0;
   logic stk_acc = 1'b0;
   logic [15:0] sp = 16'h0;
   logic guard_acc = 1'b0;
   logic [3:0] cpu_lvl = 4'h0;
   logic [3:0] ack_delay = 4'h0;
   logic cpu_ack;
   logic trap_done;
   logic in_trap;
   svc_t svc;
   xfer_t xfer;
   int fails = 0;
   int checks = 0;

   always #20 clk = ~clk;

   irq_trap_ctrl DUT (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .node_src(node_src), .shared_src(shared_src), .ext_req(ext_req), .ext_service_pin(ext_service_pin),
      .hw_trap(hw_trap),
      .stk_acc(stk_acc), .sp(sp), .guard_acc(guard_acc), .guard_wr(1'b0), .guard_addr(24'h0), .cpu_lvl(cpu_lvl),
      .cpu_ack(cpu_ack), .trap_done(trap_done), .svc(svc), .xfer(xfer));

   cpu_partner u_cpu (.clk(clk), .nrst(nrst), .svc(svc), .ack_delay(ack_delay), .cpu_ack(cpu_ack),
      .trap_done(trap_done), .in_trap(in_trap));

   task automatic complete_run;
      $display("checks %0d, fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] nd(input logic f, input logic e, input logic [3:0] p, input logic x,
      input logic [2:0] c);
      return {22'h0, f, e, p, x, c};
   endfunction

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   // n counts edges from the call; the request is seen one edge after it is set
   task automatic next_svc(input logic t, input logic [7:0] v, input logic [3:0] l, output int n);
      for (n = 0; n < 400 && svc.req !== 1'b1; n++)
         @(posedge clk);
      chk(32'({svc, in_trap}), 32'({1'b1, t, v, l, 1'b0}));
      while (svc.req === 1'b1)
         @(posedge clk);
   endtask

   task automatic t_regs;
      rd(32'h20c, 32'(CFG_RST));
      rd(32'h210, 32'(STKH_RST));
      rd(32'h214, 32'(STKL_RST));
      wr(32'h240, 32'hffffffff);
      rd(32'h240, 32'h0);
      wr(32'h8, nd(1'b0, 1'b1, 4'ha, 1'b1, 3'h5));
      rd(32'h8, nd(1'b0, 1'b1, 4'ha, 1'b1, 3'h5));
   endtask

   task automatic t_latency;
      int n;
      wr(32'h14, nd(1'b1, 1'b1, 4'h2, 1'b0, 3'h0));
      next_svc(1'b0, 8'h15, 4'h2, n);
      chk(32'(n), 32'(LAT_JC + 1));
      wr(32'h20c, 32'h0);
      wr(32'h14, nd(1'b1, 1'b1, 4'h2, 1'b0, 3'h0));
      next_svc(1'b0, 8'h15, 4'h2, n);
      chk(32'(n), 32'(LAT_NJC + 1));
      wr(32'h20c, 32'(CFG_RST));
      wr(32'h10, nd(1'b0, 1'b1, 4'h5, 1'b0, 3'h0));
      @(posedge clk);
      node_src[4] <= 1'b1;
      @(posedge clk);
      node_src[4] <= 1'b0;
      next_svc(1'b0, 8'h14, 4'h5, n);
      chk(32'(n), 32'(LAT_JC + 1));
      rd(32'h10, nd(1'b0, 1'b1, 4'h5, 1'b0, 3'h0));
   endtask

   task automatic t_prio;
      int n;
      cpu_lvl <= 4'h7;
      wr(32'hc, nd(1'b1, 1'b1, 4'h3, 1'b0, 3'h0));
      wr(32'h18, nd(1'b1, 1'b1, 4'h6, 1'b0, 3'h0));
      repeat (30) @(posedge clk);
      chk(32'(svc.req), 32'h0);
      cpu_lvl <= 4'h0;
      next_svc(1'b0, 8'h16, 4'h6, n);
      next_svc(1'b0, 8'h13, 4'h3, n);
   endtask

   task automatic t_soft;
      int n;
      wr(32'h18, nd(1'b0, 1'b1, 4'h7, 1'b0, 3'h0));
      wr(32'h208, 32'h6);
      next_svc(1'b0, 8'h16, 4'h7, n);
      for (int i = 0; i < NTRAP; i++) begin
         wr(32'h208, 32'(SWT_TRAP) + 32'(i));
         next_svc(1'b1, 8'(i), LVL_TRAP, n);
         rd(32'h204, 32'h1 << i);
         wr(32'h204, 32'h1 << i);
      end
      rd(32'h204, 32'h0);
   endtask

   // every channel once; odd channels run continuous, so only even ones end vectored
   task automatic t_xfer;
      int n;
      logic [3:0] ctl;
      logic [15:0] step;
      for (int c = 0; c < NCH; c++) begin
         ctl = {c[0], 3'(c)};
         step = ctl[CTL_WORD] ? 16'h2 : 16'h1;
         wr(32'h300 + 32'(16 * c), 32'h1000 + 32'(c));
         wr(32'h304 + 32'(16 * c), 32'h2000);
         wr(32'h308 + 32'(16 * c), 32'h1);
         wr(32'h30c + 32'(16 * c), 32'(ctl));
         wr(32'(4 * (40 + c)), nd(1'b1, 1'b1, 4'h4, 1'b1, 3'(c)));
         for (n = 0; n < 400 && xfer.req !== 1'b1; n++)
            @(posedge clk);
         chk({xfer.src, xfer.dst}, {16'h1000 + 16'(c), 16'h2000});
         chk(32'(xfer.word), 32'(ctl[CTL_WORD]));
         if (!ctl[CTL_CONT])
            next_svc(1'b0, 8'(16 + 40 + c), 4'h4, n);
         rd(32'h300 + 32'(16 * c), 32'h1000 + 32'(c) + (ctl[CTL_INCS] ? 32'(step) : 32'h0));
         rd(32'h304 + 32'(16 * c), 32'h2000 + (ctl[CTL_INCD] ? 32'(step) : 32'h0));
         rd(32'h308 + 32'(16 * c), 32'(ctl[CTL_CONT]));
         rd(32'(4 * (40 + c)), nd(1'b0, 1'b1, 4'h4, 1'b1, 3'(c)));
      end
   endtask

   task automatic t_traps;
      int n;
      wr(32'h210, 32'h1000);
      wr(32'h20c, 32'h5);
      ack_delay <= 4'h3;
      @(posedge clk);
      ext_service_pin <= 3'h1;
      next_svc(1'b1, 8'h00, LVL_TRAP, n);
      hw_trap <= 3'h1;
      stk_acc <= 1'b1;
      guard_acc <= 1'b1;
      sp <= 16'h2000;
      @(posedge clk);
      hw_trap <= 3'h0;
      stk_acc <= 1'b0;
      guard_acc <= 1'b0;
      wr(32'h24, nd(1'b1, 1'b1, 4'hf, 1'b0, 3'h0));
      next_svc(1'b1, 8'h02, LVL_TRAP, n);
      next_svc(1'b1, 8'h05, LVL_TRAP, n);
      next_svc(1'b0, 8'h19, 4'hf, n);
      rd(32'h204, 32'h25);
      wr(32'h204, 32'h25);
      rd(32'h204, 32'h0);
      ext_service_pin <= 3'h0;
      ack_delay <= 4'h0;
   endtask

   // router into node 0, shared node 108, then a guard violation
   task automatic t_route;
      int n;
      wr(32'h224, 32'h3);
      wr(32'h228, 32'h1);
      wr(32'h22c, 32'h1);
      wr(32'h0, nd(1'b0, 1'b1, 4'h3, 1'b0, 3'h0));
      ext_req <= 4'h1;
      next_svc(1'b0, 8'h10, 4'h3, n);
      ext_req <= 4'h0;
      next_svc(1'b0, 8'h10, 4'h3, n);
      wr(32'h22c, 32'h102);
      ext_req <= 4'h1;
      next_svc(1'b0, 8'h10, 4'h3, n);
      ext_req <= 4'h0;
      repeat (30) @(posedge clk);
      chk(32'(svc.req), 32'h0);
      wr(32'h200, 32'h5);
      wr(32'h1b0, nd(1'b0, 1'b1, 4'h2, 1'b0, 3'h0));
      shared_src <= 8'h20;
      @(posedge clk);
      shared_src <= 8'h00;
      next_svc(1'b0, 8'h7c, 4'h2, n);
      wr(32'h21c, 32'h1ff);
      wr(32'h20c, 32'h3);
      guard_acc <= 1'b1;
      @(posedge clk);
      guard_acc <= 1'b0;
      next_svc(1'b1, 8'h04, LVL_TRAP, n);
      rd(32'h204, 32'h10);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      chk(32'({svc.req, xfer.req, hreadyout}), 32'h0);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      t_regs;
      t_latency;
      t_prio;
      t_soft;
      t_xfer;
      t_traps;
      t_route;
      complete_run;
   end

   // the scenarios need about a thousand cycles; thirty times that means a hang
   initial begin
      #(40 * 30000);
      fails++;
      complete_run;
   end
endmodule // tb_irq_trap_ctrl
